// [common/pot_defines.svh]
// offsets, sizes and reset values for the outbound translator
// assumes inclusion by common/pot_pkg.sv and the design modules
`ifndef POT_DEFINES_SVH
`define POT_DEFINES_SVH

// ----------------------------------------
// address map
// ----------------------------------------
`define POT_ADDR_W          64
`define POT_ZERO_ADDR       64'h0000_0000_0000_0000
`define POT_MIN_REGION_BASE 64'h0000_0000_0000_1000
`define POT_WINDOW_SIZE     64'h0000_0000_1000_0000
`define POT_GUARD_SIZE      64'h0000_0000_0000_1000
`define POT_SS1_WINDOW      64'h0000_0000_2000_0000
`define POT_SS2_WINDOW      64'h0000_0000_3000_0000

// ----------------------------------------
// sizing
// ----------------------------------------
`define POT_NUM_REGIONS     4
`define POT_FIFO_DEPTH      8
`define POT_NUM_TYPES       4
`define POT_CREDIT_W        12
`define POT_CREDIT_INIT     12'hFFF

`endif

// [common/pot_pkg.sv]
// types shared by the outbound translator, its link partner model and its bench
// assumes pot_defines.svh sits beside it
`include "pot_defines.svh"

package pot_pkg;

  // ----------------------------------------
  // tlp kinds and credit classes
  // ----------------------------------------
  typedef enum logic [1:0] {
    POT_KIND_MEM = 2'b00,
    POT_KIND_MSG = 2'b01,
    POT_KIND_CPL = 2'b10,
    POT_KIND_CFG = 2'b11
  } pot_kind_t;

  typedef enum logic [1:0] {
    POT_CR_POSTED    = 2'b00,
    POT_CR_NONPOSTED = 2'b01,
    POT_CR_CPL       = 2'b10,
    POT_CR_OTHER     = 2'b11
  } pot_credit_t;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic                    en;
    logic [`POT_ADDR_W-1:0]  base;
    logic [`POT_ADDR_W-1:0]  limit;
    logic [`POT_ADDR_W-1:0]  target;
    pot_credit_t             ctype;
  } pot_region_t;

  typedef struct packed {
    pot_kind_t               kind;
    logic [`POT_ADDR_W-1:0]  addr;
    logic [31:0]             hdr01;
  } pot_tlp_t;

endpackage : pot_pkg

// [logic/pot_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`include "pot_defines.svh"

module pot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `POT_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  fifo_no_overflow_a : assert property (@(posedge clk) disable iff (srst)
    count <= DEPTH[AW:0]) else $error("fifo count above depth");

endmodule : pot_fifo

// [logic/pot_translator.sv]
// outbound region translator: matches client addresses against a region table,
// rewrites the address, debits per-class flow-control credits, buffers the tlps
// assumes region table and credit refills come from surrounding controller logic
//
// What this block does
// RULE1 - a message tlp whose third and fourth header words fall in a region is translated.
// RULE2 - a region based at zero therefore catches the many messages carrying zero there.
// RULE3 - completion tlps leave with their header untouched by any region.
// RULE4 - a completion sent while the client address hits a region debits that region's class.
// RULE5 - the client holds its address at zero while a completion is sent.
// RULE6 - software keeps every region base at or above 0x1000; the block does not enforce it and only flags a lower base on base_violation.
// RULE7 - each 256MiB subsystem window loses its first 4KB, starting at base plus 0x1000; the block checks no window, only bases below 0x1000.
// RULE8 - a hit needs an enabled region with base <= addr <= limit; lowest index wins.
`timescale 1ns/1ps
`include "pot_defines.svh"

module pot_translator
  import pot_pkg::*;
#(
  parameter int NREG  = `POT_NUM_REGIONS,
  parameter int DEPTH = `POT_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // region table
  input  wire pot_region_t [NREG-1:0]        region,
  // client side
  input  wire logic                          cl_valid,
  output logic                               cl_ready,
  input  wire pot_tlp_t                      cl_tlp,
  // credit refill from the link partner
  input  wire logic                          refill_valid,
  input  wire pot_credit_t                   refill_type,
  // link side
  output logic                               lk_valid,
  input  wire logic                          lk_ready,
  output pot_tlp_t                           lk_tlp,
  // status
  output logic [`POT_NUM_TYPES-1:0][`POT_CREDIT_W-1:0] credit,
  output logic                               hit_any,
  output logic                               base_violation
);

  // ----------------------------------------
  // region match
  // ----------------------------------------
  logic [NREG-1:0]        hit;
  logic [NREG-1:0]        low_base;
  logic [`POT_ADDR_W-1:0] xlat_addr;
  pot_credit_t            hit_type;

  // header words three and four are compared for every kind, messages included
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_match
      assign hit[g] = region[g].en &&
                      (cl_tlp.addr >= region[g].base) &&
                      (cl_tlp.addr <= region[g].limit);   // RULE8 RULE1 RULE2
      assign low_base[g] = region[g].en && (region[g].base < `POT_MIN_REGION_BASE); // RULE6
    end
  endgenerate

  // lowest index wins
  always_comb begin
    xlat_addr = cl_tlp.addr;
    hit_type  = POT_CR_POSTED;
    for (int i = NREG - 1; i >= 0; i--) begin
      if (hit[i]) begin
        xlat_addr = cl_tlp.addr - region[i].base + region[i].target;   // RULE8
        hit_type  = region[i].ctype;
      end
    end
  end

  wire is_cpl = (cl_tlp.kind == POT_KIND_CPL);
  assign hit_any = |hit;
  // a base below the guard page lets completions spend credit they never own
  assign base_violation = |low_base;                                  // RULE6 RULE7

  // ----------------------------------------
  // accept and rewrite
  // ----------------------------------------
  pot_tlp_t out_tlp;
  logic     fifo_ready;
  wire      take = cl_valid && fifo_ready;

  always_comb begin
    out_tlp = cl_tlp;
    if (hit_any && !is_cpl) out_tlp.addr = xlat_addr;                 // RULE1 RULE3
  end

  assign cl_ready = fifo_ready;

  // ----------------------------------------
  // credit counters
  // ----------------------------------------
  // a completion debits the matched region's class, not its own: preserved quirk
  wire         debit      = take && hit_any;                          // RULE4 RULE5
  pot_credit_t debit_type;
  assign debit_type = is_cpl ? hit_type : (hit_any ? hit_type : POT_CR_POSTED);

  generate
    for (g = 0; g < `POT_NUM_TYPES; g++) begin : g_credit
      wire dec = debit && (debit_type == pot_credit_t'(g));
      wire inc = refill_valid && (refill_type == pot_credit_t'(g));
      logic [`POT_CREDIT_W-1:0] next_credit;
      assign next_credit = credit[g] + `POT_CREDIT_W'(inc) - `POT_CREDIT_W'(dec);
      always_ff @(posedge clk) begin
        if (srst) credit[g] <= `POT_CREDIT_INIT;
        else      credit[g] <= next_credit;                           // RULE4
      end
    end
  endgenerate

  // ----------------------------------------
  // outbound buffer
  // ----------------------------------------
  pot_fifo #(
    .WIDTH ($bits(pot_tlp_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (cl_valid),
    .in_ready  (fifo_ready),
    .in_data   (out_tlp),
    .out_valid (lk_valid),
    .out_ready (lk_ready),
    .out_data  (lk_tlp)
  );

  // ----------------------------------------
  // step sequences for the checks
  // ----------------------------------------
  // a completion taken while the client address sits in a region, no refill beside it
  sequence cpl_hit_take_s;
    take && is_cpl && hit_any && !refill_valid;
  endsequence

  // a message taken while its third and fourth header words sit in a region
  sequence msg_hit_take_s;
    take && (cl_tlp.kind == POT_KIND_MSG) && hit_any;
  endsequence

  // a completion parked at address zero while region zero is based at zero
  sequence zero_cpl_take_s;
    take && is_cpl && (cl_tlp.addr == `POT_ZERO_ADDR) && !refill_valid &&
    region[0].en && (region[0].base == `POT_ZERO_ADDR);
  endsequence

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cpl_untouched_a : assert property (@(posedge clk) disable iff (srst)  // RULE3
    take && is_cpl |-> out_tlp == cl_tlp) else $error("completion header altered");

  msg_translated_a : assert property (@(posedge clk) disable iff (srst)  // RULE1
    msg_hit_take_s |-> out_tlp.addr == xlat_addr)
    else $error("matching message not translated");

  cpl_debit_a : assert property (@(posedge clk) disable iff (srst)  // RULE4
    cpl_hit_take_s
    |=> credit[$past(hit_type)] == $past(credit[hit_type]) - 1'b1)
    else $error("completion hit did not debit region class");

  no_hit_keep_a : assert property (@(posedge clk) disable iff (srst)  // RULE8
    take && !hit_any && !refill_valid |=> $stable(credit))
    else $error("credit moved without a hit");

  zero_base_a : assert property (@(posedge clk) disable iff (srst)  // RULE2
    region[0].en && region[0].base == `POT_ZERO_ADDR && cl_tlp.addr == `POT_ZERO_ADDR
    && region[0].limit >= `POT_ZERO_ADDR |-> hit_any && base_violation)
    else $error("zero-based region missed a zero address");

  guard_flag_a : assert property (@(posedge clk) disable iff (srst)  // RULE6
    hit_any && (cl_tlp.addr < `POT_MIN_REGION_BASE) |-> base_violation)
    else $error("low base not flagged");

  first_wins_a : assert property (@(posedge clk) disable iff (srst)  // RULE8
    hit[0] && !is_cpl |-> out_tlp.addr == cl_tlp.addr - region[0].base + region[0].target)
    else $error("lowest region did not win");

  backpressure_a : assert property (@(posedge clk) disable iff (srst)
    !lk_ready && lk_valid ##1 !lk_ready |-> $stable(lk_tlp))
    else $error("link data changed under stall");

  zero_cpl_debit_a : assert property (@(posedge clk) disable iff (srst)  // RULE5
    zero_cpl_take_s
    |=> credit[$past(region[0].ctype)] == $past(credit[region[0].ctype]) - 1'b1)
    else $error("zero-based region spared a completion");

  miss_untouched_a : assert property (@(posedge clk) disable iff (srst)  // RULE8
    take && !hit_any |-> out_tlp == cl_tlp)
    else $error("missed tlp was rewritten");

  buffer_fill_a : assert property (@(posedge clk) disable iff (srst)
    take |=> lk_valid)
    else $error("taken tlp not offered to the link");

  refill_credit_a : assert property (@(posedge clk) disable iff (srst)
    refill_valid && !(take && hit_any)
    |=> credit[$past(refill_type)] == $past(credit[refill_type]) + 1'b1)
    else $error("refill did not add a credit");

  // no disable here: the first edge after release must already show the idle state
  reset_state_a : assert property (@(posedge clk)
    $fell(srst) |-> !lk_valid && cl_ready && (credit == {`POT_NUM_TYPES{`POT_CREDIT_INIT}}))
    else $error("state after reset not idle");

  // ----------------------------------------
  // per-class credit checks
  // ----------------------------------------
  // one pair per class, so a debit landing in the wrong class shows up by name
  generate
    for (g = 0; g < `POT_NUM_TYPES; g++) begin : g_credit_chk
      class_quiet_a : assert property (@(posedge clk) disable iff (srst)  // RULE4
        !(take && hit_any && (hit_type == pot_credit_t'(g))) &&
        !(refill_valid && (refill_type == pot_credit_t'(g)))
        |=> $stable(credit[g]))
        else $error("credit class moved without a debit or refill");

      class_debit_a : assert property (@(posedge clk) disable iff (srst)  // RULE4
        take && hit_any && (hit_type == pot_credit_t'(g)) && !refill_valid
        |=> credit[g] == $past(credit[g]) - 1'b1)
        else $error("matched class not debited");
    end
  endgenerate

endmodule : pot_translator

// [testbench/pot_link_model.sv]
// link partner model: takes tlps off the link side with random back-pressure
// assumes the bench reads rx_q by hierarchical name and drives stall
`timescale 1ns/1ps

module pot_link_model
  import pot_pkg::*;
(
  // clock and reset
  input  wire logic     clk,
  input  wire logic     srst,
  // bench control
  input  wire logic     stall,
  // link side
  input  wire logic     lk_valid,
  output logic          lk_ready,
  input  wire pot_tlp_t lk_tlp
);
  pot_tlp_t rx_q[$];

  // ready drops one cycle in four so the fifo sees slow drains too
  always @(posedge clk) begin
    if (!srst && lk_valid && lk_ready) rx_q.push_back(lk_tlp);
    lk_ready <= #1 !srst && !stall && ($urandom_range(3) != 0);
  end
endmodule : pot_link_model

// [testbench/testbench.sv]
// self-checking bench for the outbound region translator
// assumes pot_pkg and the link partner model are compiled first
`timescale 1ns/1ps

module testbench
  import pot_pkg::*;
;
  logic              clk, srst, cl_valid, refill_valid, stall;
  logic              cl_ready, lk_valid, lk_ready, hit_any, base_violation;
  pot_region_t [3:0] region;
  pot_tlp_t          cl_tlp, lk_tlp, t, exp_q[$];
  pot_credit_t       refill_type;
  logic [3:0][11:0]  credit;
  logic [11:0]       cr [4];
  logic [63:0]       adr [6] = '{64'h0, 64'h1000, 64'h2000_0FFF, 64'h2000_1000,
                                 64'h2FFF_FFFF, 64'h4000_0000};
  int                err_total, checked, n, kd;

  pot_translator dut_u (.clk(clk), .srst(srst), .region(region), .cl_valid(cl_valid),
    .cl_ready(cl_ready), .cl_tlp(cl_tlp), .refill_valid(refill_valid),
    .refill_type(refill_type), .lk_valid(lk_valid), .lk_ready(lk_ready), .lk_tlp(lk_tlp),
    .credit(credit), .hit_any(hit_any), .base_violation(base_violation));
  pot_link_model link_u (.clk(clk), .srst(srst), .stall(stall), .lk_valid(lk_valid),
    .lk_ready(lk_ready), .lk_tlp(lk_tlp));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic int hit_of(logic [63:0] a);
    for (int i = 0; i < 4; i++)
      if (region[i].en && a >= region[i].base && a <= region[i].limit) return i;
    return -1;
  endfunction : hit_of

  function automatic pot_tlp_t exp_of(pot_tlp_t x);
    int h;
    h = hit_of(x.addr);
    if (h >= 0 && x.kind != POT_KIND_CPL) x.addr = x.addr - region[h].base + region[h].target;
    return x;
  endfunction : exp_of

  task automatic chk_tlp(pot_tlp_t g, pot_tlp_t e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t tlp got %h exp %h", $time, g, e);
    end
  endtask : chk_tlp

  task automatic chk_val(logic [11:0] g, logic [11:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t value got %h exp %h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_cr;
    for (int i = 0; i < 4; i++) chk_val(credit[i], cr[i]);
  endtask : chk_cr

  // valid stays up on return so back-to-back offers never toggle it
  task automatic send(pot_kind_t k, logic [63:0] a);
    int h;
    cl_tlp = '{k, a, $urandom};
    cl_valid = 1'b1;
    #1;
    h = hit_of(a);
    chk_val(12'(hit_any), 12'(h >= 0));
    n = 0;
    while (cl_ready !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    exp_q.push_back(exp_of(cl_tlp));
    if (h >= 0) cr[region[h].ctype]--;
    chk_cr;
  endtask : send

  task automatic idle;
    cl_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask : idle

  task automatic drain;
    n = 0;
    while ((lk_valid !== 1'b0 || link_u.rx_q.size() < exp_q.size()) && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_val(12'(link_u.rx_q.size()), 12'(exp_q.size()));
    while (exp_q.size() > 0 && link_u.rx_q.size() > 0) begin
      t = exp_q.pop_front();
      chk_tlp(link_u.rx_q.pop_front(), t);
    end
    exp_q.delete();
  endtask : drain

  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  initial begin
    #1_000_000;
    err_total++;
    wrap_up;
  end

  initial begin
    srst = 1'b1;
    stall = 1'b0;
    cl_valid = 1'b0;
    refill_valid = 1'b0;
    cl_tlp = '0;
    refill_type = POT_CR_CPL;
    err_total = 0;
    checked = 0;
    foreach (cr[i]) cr[i] = 12'hFFF;
    region[0] = '{1'b1, 64'h0, 64'hFFF, 64'h5000_0000, POT_CR_POSTED};
    region[1] = '{1'b1, 64'h2000_1000, 64'h2FFF_FFFF, 64'h8000_0000, POT_CR_NONPOSTED};
    region[2] = '{1'b1, 64'h2000_0000, 64'h3FFF_FFFF, 64'h9000_0000, POT_CR_OTHER};
    region[3] = '{1'b0, 64'h4000_0000, 64'h4FFF_FFFF, 64'hA000_0000, POT_CR_CPL};
    void'($urandom(32'h6BE121F6));
    repeat (4) @(posedge clk);
    #1 srst = 1'b0;
    chk_cr;
    chk_val(12'(base_violation), 12'h1);
    // every kind against zero, window guard edges, limits and a disabled region
    for (int k = 0; k < 4; k++)
      foreach (adr[i]) send(pot_kind_t'(k), adr[i]);
    repeat (40) begin
      kd = $urandom_range(3);
      // the client parks its address at zero under a completion
      send(pot_kind_t'(kd), (pot_kind_t'(kd) == POT_KIND_CPL || $urandom_range(3) == 0) ?
        64'h0 : {32'h0, 4'h2 + 4'($urandom_range(1)), 28'($urandom)});
    end
    idle;
    drain;
    // fill the buffer against a stalled link until it refuses
    stall = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    repeat (8) send(POT_KIND_MEM, 64'h2000_2000);
    chk_val(12'(cl_ready), 12'h0);
    idle;
    stall = 1'b0;
    drain;
    refill_valid = 1'b1;
    @(posedge clk);
    #1 refill_valid = 1'b0;
    cr[POT_CR_CPL]++;
    chk_cr;
    region[0] = '{1'b1, 64'h1000, 64'h1FFF, 64'h5000_0000, POT_CR_POSTED};
    #1 chk_val(12'(base_violation), 12'h0);
    send(POT_KIND_MSG, 64'h0);
    send(POT_KIND_CPL, 64'h0);
    idle;
    drain;
    wrap_up;
  end
endmodule : testbench
